// File: design/nand_host.sv
// Host controller that drives a NAND device through its strobes and bus.
`timescale 1ns/1ps
`include "nand_host_regs.svh"
module nand_host
  import nand_host_pkg::*;
#(
  parameter int PHASE = `PHASE_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Request side.
  input wire logic req_valid,
  input wire nand_host_pkg::req_t req,
  output logic req_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic abort,
  output logic busy,
  // Device pins.
  output nand_host_pkg::pins_t pins,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  import nand_host_pkg::*;

  // Reads need the strobe low past both bus sampler stages, so PHASE >= 3.
  if (PHASE < 3 || PHASE > 255) begin : g_phase_chk
    $error("PHASE must be 3..255");
  end

  typedef enum logic [2:0] {
    S_IDLE,
    S_SETUP,
    S_LOW,
    S_HIGH,
    S_GUARD
  } state_t;

  localparam pins_t PINS_IDLE = '{cs_n: 1'b1, cmd_latch: 1'b0,
    addr_latch: 1'b0, write_strobe_n: 1'b1, read_strobe_n: 1'b1,
    write_protect_n: 1'b0};

  state_t state_r, state_nxt;
  req_t cur_r, cur_nxt;
  pins_t pins_r, pins_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] io_out_r, io_out_nxt;
  logic io_oe_r, io_oe_nxt;
  logic ready_r, ready_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic busy_r, busy_nxt;
  logic [2:0] rb_sync_r;
  logic [7:0] io_s1_r, io_s2_r;
  logic dev_ready;

  // Three-stage ready/busy sampler; second and third stages must agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_sync_r <= 3'h0;
      busy_r <= 1'b1;
      io_s1_r <= 8'h00;
      io_s2_r <= 8'h00;
    end else begin
      rb_sync_r <= {rb_sync_r[1:0], ready_busy_n};
      busy_r <= busy_nxt;
      io_s1_r <= io_in;
      io_s2_r <= io_s1_r;
    end
  end

  // Busy follows the agreed sample, so glitches do not flip it.
  // cache read busy too
  always_comb begin
    busy_nxt = busy_r;
    if (rb_sync_r[2] == rb_sync_r[1]) begin
      busy_nxt = ~rb_sync_r[2];
    end
  end
  assign dev_ready = ~busy_r;

  // Cycle sequencer: one request becomes one strobe cycle.
  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    pins_nxt = pins_r;
    cnt_nxt = cnt_r;
    io_out_nxt = io_out_r;
    io_oe_nxt = io_oe_r;
    ready_nxt = 1'b0;
    rd_valid_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    case (state_r)
      S_IDLE: begin
        pins_nxt.cs_n = 1'b1;
        pins_nxt.cmd_latch = 1'b0;
        pins_nxt.addr_latch = 1'b0;
        io_oe_nxt = 1'b0;
        // only status or reset while busy
        if (req_valid && !ready_r &&
            (dev_ready || (req.kind == OP_CMD &&
            (req.data == `CMD_STATUS || req.data == `CMD_RESET)))) begin
          cur_nxt = req;
          ready_nxt = 1'b1;
          state_nxt = S_SETUP;
          cnt_nxt = 8'(PHASE);
          pins_nxt.cs_n = 1'b0;
          pins_nxt.cmd_latch = (req.kind == OP_CMD);
          pins_nxt.addr_latch = (req.kind == OP_ADDR);
          // data input needs protect high
          // Non-modify command, address and read cycles keep the level, so a status poll cannot abort.
          if (req.modify || req.kind == OP_WRITE) begin
            pins_nxt.write_protect_n = 1'b1;
          end
          io_oe_nxt = (req.kind != OP_READ);
          io_out_nxt = req.data;
        end
      end
      S_SETUP: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          cnt_nxt = 8'(PHASE);
          state_nxt = S_LOW;
          if (cur_r.kind == OP_READ) begin
            pins_nxt.read_strobe_n = 1'b0;
          end else begin
            pins_nxt.write_strobe_n = 1'b0;
          end
        end
      end
      S_LOW: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          cnt_nxt = 8'(PHASE);
          state_nxt = S_HIGH;
          pins_nxt.write_strobe_n = 1'b1;
          pins_nxt.read_strobe_n = 1'b1;
          if (cur_r.kind == OP_READ) begin
            rd_valid_nxt = 1'b1;
            rd_data_nxt = io_s2_r;
          end
        end
      end
      S_HIGH: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          state_nxt = S_GUARD;
          io_oe_nxt = 1'b0;
          pins_nxt.cmd_latch = 1'b0;
          pins_nxt.addr_latch = 1'b0;
        end
      end
      S_GUARD: begin
        state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
    if (abort) begin
      pins_nxt.write_protect_n = 1'b0;
    end
    if (!dev_ready && state_r == S_IDLE) begin
      pins_nxt.write_strobe_n = 1'b1;
      pins_nxt.read_strobe_n = 1'b1;
    end
  end

  // State registers for the sequencer.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      cur_r <= '0;
      pins_r <= PINS_IDLE;
      cnt_r <= 8'h00;
      io_out_r <= 8'h00;
      io_oe_r <= 1'b0;
      ready_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      pins_r <= pins_nxt;
      cnt_r <= cnt_nxt;
      io_out_r <= io_out_nxt;
      io_oe_r <= io_oe_nxt;
      ready_r <= ready_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign pins = pins_r;
  assign io_out = io_out_r;
  assign io_oe = io_oe_r;
  assign req_ready = ready_r;
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  assign busy = busy_r;

  // Latch strobes never both high.
  latch_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(pins_r.cmd_latch && pins_r.addr_latch))
    else $error("both latch strobes high");
  // Command strobe only with select low.
  cmd_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins_r.write_strobe_n) && pins_r.cmd_latch |-> !pins_r.cs_n
    && pins_r.read_strobe_n) else $error("command latch bad");
  // Address strobe only with select low.
  addr_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins_r.write_strobe_n) && pins_r.addr_latch |-> !pins_r.cs_n
    && !pins_r.cmd_latch) else $error("address latch bad");
  // Data input has protect high.
  data_prot_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins_r.write_strobe_n) && !pins_r.cmd_latch &&
    !pins_r.addr_latch |-> pins_r.write_protect_n)
    else $error("data input with protect low");
  // Strobes never low together.
  strobe_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
    pins_r.write_strobe_n || pins_r.read_strobe_n)
    else $error("both strobes low");
  // Read data appears when read strobe rises.
  rd_pace_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins_r.read_strobe_n) |-> rd_valid_r)
    else $error("read byte not captured");
  // Abort forces protect low next cycle.
  abort_prot_a: assert property (@(posedge clk) disable iff (!rst_n)
    abort |=> !pins_r.write_protect_n)
    else $error("abort did not drop protect");
  // Bus released while reading.
  read_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
    !pins_r.read_strobe_n |-> !io_oe_r)
    else $error("bus driven during read");
endmodule // nand_host

// File: design/nand_host_regs.svh
// Constants for the NAND bus host: command codes, address layout, timing.
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH
`define CMD_PAGE_READ 8'h00
`define CMD_READ_CONF 8'h30
`define CMD_COPYBACK_CONF 8'h35
`define CMD_COL_CHANGE 8'h05
`define CMD_COL_CONF 8'hE0
`define CMD_CACHE_READ 8'h31
`define CMD_CACHE_END 8'h3F
`define CMD_READ_ID 8'h90
`define CMD_STATUS 8'h70
`define CMD_PROG 8'h80
`define CMD_PROG_CONF 8'h10
`define CMD_CACHE_PROG_CONF 8'h15
`define CMD_RAND_IN 8'h85
`define CMD_ERASE 8'h60
`define CMD_ERASE_CONF 8'hD0
`define CMD_RESET 8'hFF
`define CMD_PARAM 8'hEC
`define CMD_UID 8'hED
`define CMD_GET_FEAT 8'hEE
`define CMD_SET_FEAT 8'hEF
`define COL_BITS 12
`define PAGE_LSB 12
`define BLOCK_LSB 18
`define PHASE_NS 20
`define CLK_NS 4
`define PHASE_CYC ((`PHASE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// File: design/nand_host_pkg.sv
// Types for the NAND bus host.
package nand_host_pkg;
  typedef enum logic [1:0] {
    OP_CMD,
    OP_ADDR,
    OP_WRITE,
    OP_READ
  } op_kind_t;
  typedef struct packed {
    op_kind_t kind;
    logic [7:0] data;
    logic modify;
  } req_t;
  typedef struct packed {
    logic cs_n;
    logic cmd_latch;
    logic addr_latch;
    logic write_strobe_n;
    logic read_strobe_n;
    logic write_protect_n;
  } pins_t;
endpackage

// File: test/nand_dev_model.sv
// Behavioural NAND device that answers the host's strobes and bus.
`timescale 1ns/1ps
module nand_dev_model (
  // Host pins.
  input wire nand_host_pkg::pins_t pins,
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  // Device answers.
  output logic [7:0] io_in,
  output logic ready_busy_n
);
  import nand_host_pkg::*;
  logic [7:0] last_cmd = 8'h00;
  logic [7:0] dq = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] adr [4];
  logic [7:0] dat [4];
  logic drv = 1'b0;
  logic prog = 1'b0;
  int na = 0;
  int nd = 0;
  int col = 0;
  int busy_left = 0;
  // Shared bus, busy pin.
  // A released bus shows the inverse of its last value, so stale data fails.
  assign io_in = io_oe ? io_out : (drv ? dq : ~last);
  assign ready_busy_n = (busy_left == 0);
  always @(io_out, io_oe, dq, drv) begin
    if (io_oe) last = io_out;
    else if (drv) last = dq;
  end
  // Busy time runs down in steps of one host clock.
  always #4 if (busy_left > 0) busy_left--;
  task automatic take_cmd(input logic [7:0] c);
    if (busy_left > 0 && c != 8'h70 && c != 8'hFF) return;
    last_cmd = c;
    case (c)
      8'h00, 8'h05, 8'h80: begin
        na = 0;
        nd = 0;
      end
      8'h30, 8'h31, 8'h3F: begin
        col = {adr[1][3:0], adr[0]};
        busy_left = 25;
      end
      8'hE0: col = {adr[1][3:0], adr[0]};
      8'h10: if (pins.write_protect_n && nd > 0) begin
        prog = 1'b1;
        busy_left = 100;
      end
      8'hFF: busy_left = 0;
      default: ;
    endcase
  endtask
  always @(posedge pins.write_strobe_n) begin
    if (!pins.cs_n && pins.read_strobe_n) begin
      if (pins.cmd_latch && !pins.addr_latch) take_cmd(io_in);
      else if (pins.addr_latch && !pins.cmd_latch) begin
        if (na < 4) adr[na] = io_in;
        na++;
      end else if (!pins.addr_latch && !pins.cmd_latch) begin
        if (pins.write_protect_n && nd < 4) dat[nd] = io_in;
        if (pins.write_protect_n) nd++;
      end
    end
  end
  always @(negedge pins.write_protect_n) begin
    if (prog) busy_left = 0;
    prog = 1'b0;
  end
  always @(negedge pins.read_strobe_n) begin
    if (!pins.cs_n && !pins.cmd_latch && !pins.addr_latch &&
        pins.write_strobe_n) begin
      dq = col[7:0] ^ 8'h5A;
      col++;
      drv = 1'b1;
    end
  end
  // Output stops once the host deselects or opens a latch cycle.
  always @(posedge pins.cs_n, posedge pins.cmd_latch, posedge pins.addr_latch)
    drv = 1'b0;
endmodule // nand_dev_model

// File: test/nand_async_bus_command_interface_tb.sv
// Self-checking bench for the NAND bus host against a device model.
`timescale 1ns/1ps
module nand_async_bus_command_interface_tb;
  import nand_host_pkg::*;
  localparam int P = 3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic abort = 1'b0;
  req_t req = '0;
  logic req_ready, rd_valid, busy, io_oe, ready_busy_n;
  logic [7:0] rd_data, io_out, io_in, got;
  pins_t pins;
  int fail_count = 0;
  int num_checks = 0;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
    fail_count++; $display("MISMATCH t=%0t got %h exp %h", $time, a, b); \
    end end
  always #2 clk = ~clk;
  nand_host #(.PHASE(P)) dut_u (.clk(clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .abort(abort), .busy(busy),
    .pins(pins), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
    .ready_busy_n(ready_busy_n));
  nand_dev_model dev_u (.pins(pins), .io_out(io_out), .io_oe(io_oe),
    .io_in(io_in), .ready_busy_n(ready_busy_n));
  // One request: held until taken, then the transfer is left to finish.
  // select held, slow capture, strobes idle
  task automatic send(input op_kind_t k, input logic [7:0] d,
                      input logic m);
    int n;
    n = 0;
    got = 8'hxx;
    req_valid <= 1'b1;
    req <= '{kind: k, data: d, modify: m};
    do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 100);
    req_valid <= 1'b0;
    if (n >= 100) fail_count++;
    repeat (3 * P + 4) begin
      @(posedge clk);
      if (rd_valid === 1'b1) got = rd_data;
    end
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 200) begin @(posedge clk); n++; end
    `CHK(busy, v);
  endtask
  task automatic t_reset();
    repeat (10) @(posedge clk);
    `CHK(pins.cs_n, 1'b1);
    `CHK(io_oe, 1'b0);
    `CHK(busy, 1'b1);
  endtask
  // Page read, a refused command while busy, reads and a column change.
  // command, address, then data cycles
  task automatic t_read();
    send(OP_CMD, 8'h00, 1'b0);
    send(OP_ADDR, 8'h34, 1'b0);
    send(OP_ADDR, 8'h01, 1'b0);
    send(OP_ADDR, 8'h07, 1'b0);
    send(OP_ADDR, 8'h02, 1'b0);
    send(OP_CMD, 8'h30, 1'b0);
    `CHK(dev_u.last_cmd, 8'h30);
    `CHK({dev_u.adr[3], dev_u.adr[2]}, 16'h0207);
    `CHK(dev_u.col[11:0], 12'h134);
    wait_busy(1'b1);
    req_valid <= 1'b1;
    req <= '{kind: OP_CMD, data: 8'h90, modify: 1'b0};
    repeat (6) begin @(posedge clk); `CHK(req_ready, 1'b0); end
    req_valid <= 1'b0;
    wait_busy(1'b0);
    for (int i = 0; i < 3; i++) begin
      send(OP_READ, 8'h00, 1'b0);
      `CHK(got, (8'h34 + i[7:0]) ^ 8'h5A);
    end
    send(OP_CMD, 8'h05, 1'b0);
    send(OP_ADDR, 8'h23, 1'b0);
    send(OP_ADDR, 8'h01, 1'b0);
    send(OP_CMD, 8'hE0, 1'b0);
    send(OP_READ, 8'h00, 1'b0);
    `CHK(got, 8'h23 ^ 8'h5A);
    send(OP_CMD, 8'h31, 1'b0);
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask
  // Program with data, status while busy, then an abort mid-program.
  task automatic t_prog();
    send(OP_CMD, 8'h80, 1'b1);
    repeat (4) send(OP_ADDR, 8'h00, 1'b1);
    send(OP_WRITE, 8'hA1, 1'b0);
    send(OP_WRITE, 8'hB2, 1'b0);
    `CHK(dev_u.nd, 2);
    `CHK(dev_u.dat[0], 8'hA1);
    `CHK(dev_u.dat[1], 8'hB2);
    send(OP_CMD, 8'h10, 1'b1);
    wait_busy(1'b1);
    send(OP_CMD, 8'h70, 1'b0);
    `CHK(dev_u.last_cmd, 8'h70);
    `CHK(ready_busy_n, 1'b0);
    abort <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(pins.write_protect_n, 1'b0);
    abort <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(ready_busy_n, 1'b1);
    wait_busy(1'b0);
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    t_reset();
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    t_read();
    t_prog();
    tally_and_finish();
  end
  // Hang guard: the sequence needs well under 5000 cycles.
  initial begin
    #20000;
    fail_count++;
    tally_and_finish();
  end
endmodule // nand_async_bus_command_interface_tb
